// ---- core/vbla_limiter.v ----
// vbat tracking limiter with sag guard and group gain alignment
`timescale 1ns/1ps
`include "vbla_map.vh"
// How it works
// - threshold falls with vbat below knee voltage
// - gradient codes give 1, 1.5, 2, 4 V/V
// - tracked threshold never below programmed floor
// - sag guard has priority, attacks within 10 us
// - sag guard enabled at reset, works without limiter
// - sag threshold 4.5 V plus 25 mV per code
// - sag guard owns attack rate, step, hold
// - release after sag uses limiter release rate
// - sag attack rate 5 us doubling to 640
// - sag attack step 0.5 to 2 dB
// - sag hold 0 to 1000 ms table
// - power-off on sag until shutdown passes
// - sag hold forever until mute, shutdown or clear; limiter hold stays timed
// - hold release bit is write-one strobe, reads zero
// - own reduction sent in chosen 8-bit slot
// - first slot field is slot 0 to 63
// - eight listen bits pick slots first+n
// - combine by minimum, maximum or nonzero minimum
// - limiter attacks only while level exceeds threshold
// - after sag clears, hold then release
// - one shared maximum attenuation stops attack
module vbla_limiter #(
  parameter CYC_PER_US = `VBLA_CLK_HZ / 1000000,
  parameter US_PER_MS = `VBLA_US_PER_MS
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // measurements and device state, same clock
  input wire [11:0] vbatCode,
  input wire [15:0] peakLevelMv,
  input wire muteIn,
  input wire shutdownIn,
  // tdm link, asynchronous pins
  input wire tdmBclk,
  input wire tdmFsync,
  input wire tdmDin,
  output reg serialAudioOut,
  output reg serialAudioOutEn,
  // results
  output reg [7:0] gainReduction,
  output reg powerOff
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ATK = 3'd1;
  localparam ST_SAG = 3'd2;
  localparam ST_HOLD = 3'd3;
  localparam ST_INFH = 3'd4;
  localparam ST_REL = 3'd5;
  localparam [31:0] US_CYC = CYC_PER_US - 1;

  // 2 V plus 100 mV per code
  function [15:0] mv7;
    input [6:0] code;
    mv7 = 16'h07D0 + {9'h000, code} * 16'h0064;
  endfunction
  // hold table in ms
  function [9:0] holdMs;
    input [2:0] code;
    case (code)
      3'h0: holdMs = 10'h000;
      3'h1: holdMs = 10'h00A;
      3'h2: holdMs = 10'h019;
      3'h3: holdMs = 10'h032;
      3'h4: holdMs = 10'h064;
      3'h5: holdMs = 10'h0FA;
      3'h6: holdMs = 10'h1F4;
      default: holdMs = 10'h3E8;
    endcase
  endfunction
  // attack interval in us: 5 doubling per code
  function [9:0] atkUs;
    input [2:0] code;
    atkUs = 10'h005 << code;
  endfunction

  reg [31:0] ctrlFf, lim1Ff, lim2Ff, sagFf, alignFf;
  reg holdRelFf;
  reg [7:0] awAddrFf;
  reg [31:0] wDataFf;
  reg [3:0] wStrbFf;
  reg awHaveFf, wHaveFf;

  // field views
  wire limEn = ctrlFf[`VBLA_LIM_EN_POS];
  wire sagEn = ctrlFf[`VBLA_SAG_EN_POS];
  wire pwrOffEn = ctrlFf[`VBLA_PWR_OFF_POS];
  wire holdInf = ctrlFf[`VBLA_HOLD_INF_POS];
  wire alignEn = ctrlFf[`VBLA_ALIGN_EN_POS];
  wire txEn = ctrlFf[`VBLA_TX_EN_POS];
  wire [1:0] combSel = ctrlFf[`VBLA_COMB_POS+1:`VBLA_COMB_POS];
  wire [1:0] grad = lim1Ff[`VBLA_GRAD_POS+1:`VBLA_GRAD_POS];
  wire [4:0] maxCode = lim2Ff[`VBLA_MAXATT_POS+4:`VBLA_MAXATT_POS];
  wire [7:0] sagTh = sagFf[`VBLA_STH_POS+7:`VBLA_STH_POS];
  wire [5:0] firstSlot = alignFf[`VBLA_FIRST_POS+5:`VBLA_FIRST_POS];
  wire [5:0] txSlot = alignFf[`VBLA_TXSLOT_POS+5:`VBLA_TXSLOT_POS];
  wire [7:0] listen = alignFf[`VBLA_LISTEN_POS+7:`VBLA_LISTEN_POS];

  // threshold tracking in mV; vbat code is 1/256 V
  wire [18:0] vbatProd = {7'h00, vbatCode} * 19'h0007D;
  wire [15:0] vbatMv = vbatProd[18:3] >> 2;
  wire [15:0] ceilMv = mv7(lim1Ff[`VBLA_CEIL_POS+6:`VBLA_CEIL_POS]);
  wire [15:0] kneeMv = mv7(lim1Ff[`VBLA_KNEE_POS+6:`VBLA_KNEE_POS]);
  wire [15:0] floorMv = mv7(lim1Ff[`VBLA_FLOOR_POS+6:`VBLA_FLOOR_POS]);
  wire [15:0] dropMv = (vbatMv < kneeMv) ? kneeMv - vbatMv : 16'h0000;
  reg [19:0] dropScaled;
  // slope in half volts per volt
  always @* begin
    case (grad)
      2'h0: dropScaled = {4'h0, dropMv} * 20'h00002;
      2'h1: dropScaled = {4'h0, dropMv} * 20'h00003;
      2'h2: dropScaled = {4'h0, dropMv} * 20'h00004;
      default: dropScaled = {4'h0, dropMv} * 20'h00008;
    endcase
  end
  wire [19:0] dropEff = dropScaled >> 1;
  wire [15:0] trackMv = ({4'h0, ceilMv} > dropEff) ? ceilMv - dropEff[15:0] : 16'h0000;
  wire [15:0] threshMv = (trackMv < floorMv) ? floorMv : trackMv;
  // sag threshold 4.5 V plus 25 mV per code
  wire [15:0] sagMv = 16'h1194 + {8'h00, sagTh} * 16'h0019;
  wire sagAct = sagEn && (vbatMv < sagMv);
  wire limAct = limEn && (peakLevelMv > threshMv);

  // quarter-dB steps and shared cap
  wire [7:0] maxAtt = {2'h0, maxCode, 1'b0} + 8'h04;
  wire [7:0] limStep = 8'h01 << lim2Ff[`VBLA_LSTEP_POS+1:`VBLA_LSTEP_POS];
  wire [7:0] relStep = 8'h01 << lim2Ff[`VBLA_RSTEP_POS+1:`VBLA_RSTEP_POS];
  wire [1:0] sagStepCode = sagFf[`VBLA_SSTEP_POS+1:`VBLA_SSTEP_POS];
  wire [7:0] sagStep = {5'h00, sagStepCode, 1'b0} + 8'h02;
  wire [9:0] limRateUs = atkUs(lim2Ff[`VBLA_LATK_POS+2:`VBLA_LATK_POS]);
  wire [9:0] sagRateUs = atkUs(sagFf[`VBLA_SATK_POS+2:`VBLA_SATK_POS]);
  wire [31:0] limHoldUs = holdMs(lim2Ff[`VBLA_LHOLD_POS+2:`VBLA_LHOLD_POS]) * US_PER_MS;
  wire [31:0] sagHoldUs = holdMs(sagFf[`VBLA_SHOLD_POS+2:`VBLA_SHOLD_POS]) * US_PER_MS;
  reg [10:0] relMs;
  // release time per step, shared by both paths
  always @* begin
    case (lim2Ff[`VBLA_LREL_POS+2:`VBLA_LREL_POS])
      3'h0: relMs = 11'h00A;
      3'h1: relMs = 11'h032;
      3'h2: relMs = 11'h064;
      3'h3: relMs = 11'h0FA;
      3'h4: relMs = 11'h1F4;
      3'h5: relMs = 11'h2EE;
      3'h6: relMs = 11'h3E8;
      default: relMs = 11'h5DC;
    endcase
  end
  wire [31:0] relUs = relMs * US_PER_MS;

  reg [7:0] grLocalFf;
  reg [2:0] stFf;
  reg [15:0] usCntFf;
  reg [9:0] rateCntFf;
  reg [20:0] holdCntFf;
  reg [20:0] relCntFf;
  wire usTick = (usCntFf == US_CYC[15:0]);
  wire [7:0] atkStep = (stFf == ST_SAG) ? sagStep : limStep;
  wire [8:0] grSum = {1'b0, grLocalFf} + {1'b0, atkStep};
  wire [7:0] nxt_grAtk = (grSum > {1'b0, maxAtt}) ? maxAtt : grSum[7:0];
  wire [7:0] nxt_grRel = (grLocalFf > relStep) ? grLocalFf - relStep : 8'h00;

  // microsecond tick keeps every timer table in real time
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      usCntFf <= 16'h0000;
    end else begin
      usCntFf <= usTick ? 16'h0000 : usCntFf + 16'h0001;
    end
  end

  // gain state machine; sag guard outranks the limiter
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stFf <= ST_IDLE;
      grLocalFf <= 8'h00;
      rateCntFf <= 10'h000;
      holdCntFf <= 21'h000000;
      relCntFf <= 21'h000000;
    end else if (sagAct) begin
      if (stFf != ST_SAG) begin
        stFf <= ST_SAG;
        rateCntFf <= 10'h000;
      end else if (usTick) begin
        if (rateCntFf == 10'h000) begin
          grLocalFf <= nxt_grAtk;
          rateCntFf <= sagRateUs - 10'h001;
        end else begin
          rateCntFf <= rateCntFf - 10'h001;
        end
      end
    end else if (limAct && stFf != ST_SAG) begin
      if (stFf != ST_ATK) begin
        stFf <= ST_ATK;
        rateCntFf <= 10'h000;
      end else if (usTick) begin
        if (rateCntFf == 10'h000) begin
          grLocalFf <= nxt_grAtk;
          rateCntFf <= limRateUs - 10'h001;
        end else begin
          rateCntFf <= rateCntFf - 10'h001;
        end
      end
    end else begin
      case (stFf)
        ST_IDLE: begin
          stFf <= ST_IDLE;
        end
        ST_SAG: begin
          if (holdInf) begin
            stFf <= ST_INFH;
          end else begin
            stFf <= ST_HOLD;
            holdCntFf <= sagHoldUs[20:0];
          end
        end
        ST_ATK: begin
          stFf <= ST_HOLD;
          holdCntFf <= limHoldUs[20:0];
        end
        ST_HOLD: begin
          if (usTick) begin
            if (holdCntFf == 21'h000000) begin
              stFf <= ST_REL;
              relCntFf <= 21'h000000;
            end else begin
              holdCntFf <= holdCntFf - 21'h000001;
            end
          end
        end
        ST_INFH: begin
          if (holdRelFf || muteIn || shutdownIn) begin
            stFf <= ST_REL;
            relCntFf <= 21'h000000;
          end
        end
        ST_REL: begin
          if (grLocalFf == 8'h00) begin
            stFf <= ST_IDLE;
          end else if (usTick) begin
            if (relCntFf == 21'h000000) begin
              grLocalFf <= nxt_grRel;
              relCntFf <= relUs[20:0] - 21'h000001;
            end else begin
              relCntFf <= relCntFf - 21'h000001;
            end
          end
        end
        default: stFf <= ST_IDLE;
      endcase
    end
  end

  // power-off latch; a new sag event wins over the shutdown clear
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerOff <= 1'b0;
    end else if (sagAct && pwrOffEn) begin
      powerOff <= 1'b1;
    end else if (shutdownIn) begin
      powerOff <= 1'b0;
    end
  end

  // link pins: two flops each, third bclk stage only for edges
  reg bclkS1, bclkS2, bclkS3, fsS1, fsS2, dinS1, dinS2, fsPrevFf, framedFf;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {bclkS1, bclkS2, bclkS3} <= 3'h0;
      {fsS1, fsS2, dinS1, dinS2} <= 4'h0;
    end else begin
      {bclkS1, bclkS2, bclkS3} <= {tdmBclk, bclkS1, bclkS2};
      {fsS1, fsS2, dinS1, dinS2} <= {tdmFsync, fsS1, tdmDin, dinS1};
    end
  end
  wire bclkRise = bclkS2 && !bclkS3;
  wire bclkFall = !bclkS2 && bclkS3;

  // bit position; bit 0 of slot 0 follows the frame-sync edge by one bclk
  reg [8:0] posFf;
  reg [7:0] rxShiftFf, txShiftFf;
  wire [5:0] lstIdx = posFf[8:3] - firstSlot;
  wire lstHit = (lstIdx < 6'h08) && listen[lstIdx[2:0]];
  wire [7:0] rxByte = {rxShiftFf[6:0], dinS2};
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      posFf <= 9'h1FF;
      fsPrevFf <= 1'b0;
      framedFf <= 1'b0;
      rxShiftFf <= 8'h00;
    end else if (bclkRise) begin
      fsPrevFf <= fsS2;
      if (fsS2 && !fsPrevFf) begin
        posFf <= 9'h000;
        framedFf <= 1'b1;
      end else begin
        rxShiftFf <= rxByte;
        if (posFf != 9'h1FF) begin
          posFf <= posFf + 9'h001;
        end
      end
    end
  end

  // one byte store per listened slot, msb first on the wire
  // each slot owns its byte so no register has two writers
  wire [63:0] rxVal;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gSlot
      reg [7:0] slotValFf;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          slotValFf <= 8'h00;
        end else if (bclkRise && !(fsS2 && !fsPrevFf) && framedFf && posFf[2:0] == 3'h7
                     && lstHit && lstIdx[2:0] == g) begin
          slotValFf <= rxByte;
        end
      end
      assign rxVal[g*8+7:g*8] = slotValFf;
    end
  endgenerate

  // transmit own reduction, changed on the falling bclk
  wire inTxSlot = framedFf && txEn && (posFf[8:3] == txSlot);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serialAudioOut <= 1'b0;
      serialAudioOutEn <= 1'b0;
      txShiftFf <= 8'h00;
    end else if (bclkFall) begin
      serialAudioOutEn <= inTxSlot;
      if (!inTxSlot) begin
        serialAudioOut <= 1'b0;
      end else if (posFf[2:0] == 3'h0) begin
        serialAudioOut <= grLocalFf[7];
        txShiftFf <= {grLocalFf[6:0], 1'b0};
      end else begin
        serialAudioOut <= txShiftFf[7];
        txShiftFf <= {txShiftFf[6:0], 1'b0};
      end
    end
  end

  // group combine over listened slots
  integer i;
  reg [7:0] cMin, cMax, cNz, comb, v;
  reg anyNz;
  always @* begin
    cMin = 8'hFF;
    cMax = 8'h00;
    cNz = 8'hFF;
    anyNz = 1'b0;
    v = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (listen[i]) begin
        v = rxVal[i*8 +: 8];
        if (v < cMin) cMin = v;
        if (v > cMax) cMax = v;
        if (v != 8'h00 && v < cNz) cNz = v;
        if (v != 8'h00) anyNz = 1'b1;
      end
    end
    case (combSel)
      2'h1: comb = cMax;
      2'h2: comb = anyNz ? cNz : 8'h00;
      default: comb = cMin; // reserved code behaves as minimum
    endcase
  end
  wire alignOn = alignEn && (listen != 8'h00);
  wire [7:0] combCap = (comb > maxAtt) ? maxAtt : comb;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gainReduction <= 8'h00;
    end else begin
      gainReduction <= alignOn ? combCap : grLocalFf;
    end
  end

  // byte-lane merge for register writes
  function [31:0] mrg;
    input [31:0] old, dat, msk;
    input [3:0] st;
    reg [31:0] be;
    begin
      be = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
      mrg = ((old & ~be) | (dat & be)) & msk;
    end
  endfunction

  // axi write: address and data taken in either order
  wire doWr = awHaveFf && wHaveFf && !s_axi_bvalid;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      {awHaveFf, wHaveFf} <= 2'h0;
      awAddrFf <= 8'h00;
      wDataFf <= 32'h0000_0000;
      wStrbFf <= 4'h0;
      holdRelFf <= 1'b0;
      ctrlFf <= `VBLA_CTRL_RST;
      lim1Ff <= `VBLA_LIM1_RST;
      lim2Ff <= `VBLA_LIM2_RST;
      sagFf <= `VBLA_SAG_RST;
      alignFf <= `VBLA_ALIGN_RST;
    end else begin
      holdRelFf <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrFf <= s_axi_awaddr;
        awHaveFf <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataFf <= s_axi_wdata;
        wStrbFf <= s_axi_wstrb;
        wHaveFf <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWr) begin
        {awHaveFf, wHaveFf} <= 2'h0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awAddrFf)
          `VBLA_CTRL_OFS: begin
            ctrlFf <= mrg(ctrlFf, wDataFf, `VBLA_CTRL_MSK, wStrbFf);
            holdRelFf <= wStrbFf[0] && wDataFf[`VBLA_HOLD_REL_POS];
          end
          `VBLA_LIM1_OFS: lim1Ff <= mrg(lim1Ff, wDataFf, `VBLA_LIM1_MSK, wStrbFf);
          `VBLA_LIM2_OFS: lim2Ff <= mrg(lim2Ff, wDataFf, `VBLA_LIM2_MSK, wStrbFf);
          `VBLA_SAG_OFS: sagFf <= mrg(sagFf, wDataFf, `VBLA_SAG_MSK, wStrbFf);
          `VBLA_ALIGN_OFS: alignFf <= mrg(alignFf, wDataFf, `VBLA_ALIGN_MSK, wStrbFf);
          `VBLA_STAT_OFS: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read; hold release bit never stored so reads zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `VBLA_CTRL_OFS: s_axi_rdata <= ctrlFf;
        `VBLA_LIM1_OFS: s_axi_rdata <= lim1Ff;
        `VBLA_LIM2_OFS: s_axi_rdata <= lim2Ff;
        `VBLA_SAG_OFS: s_axi_rdata <= sagFf;
        `VBLA_ALIGN_OFS: s_axi_rdata <= alignFf;
        `VBLA_STAT_OFS: s_axi_rdata <= {10'h000, limAct, powerOff, sagAct, stFf,
                                        grLocalFf, gainReduction};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // vbla_limiter

// ---- core/vbla_map.vh ----
// register map, field positions, reset values and timing for the vbat limiter
`ifndef VBLA_MAP_VH
`define VBLA_MAP_VH
`define VBLA_CTRL_OFS 8'h00
`define VBLA_LIM1_OFS 8'h04
`define VBLA_LIM2_OFS 8'h08
`define VBLA_SAG_OFS 8'h0C
`define VBLA_ALIGN_OFS 8'h10
`define VBLA_STAT_OFS 8'h14
`define VBLA_CTRL_RST 32'h0000_0002
`define VBLA_LIM1_RST 32'h001E_586E
`define VBLA_LIM2_RST 32'h0010_5662
`define VBLA_SAG_RST 32'h0006_1214
`define VBLA_ALIGN_RST 32'h0000_0000
`define VBLA_CTRL_MSK 32'h0000_036F
`define VBLA_LIM1_MSK 32'h037F_7F7F
`define VBLA_LIM2_MSK 32'h001F_F777
`define VBLA_SAG_MSK 32'h0007_37FF
`define VBLA_ALIGN_MSK 32'h00FF_3F3F
`define VBLA_LIM_EN_POS 0
`define VBLA_SAG_EN_POS 1
`define VBLA_PWR_OFF_POS 2
`define VBLA_HOLD_INF_POS 3
`define VBLA_HOLD_REL_POS 4
`define VBLA_ALIGN_EN_POS 5
`define VBLA_TX_EN_POS 6
`define VBLA_COMB_POS 8
`define VBLA_CEIL_POS 0
`define VBLA_KNEE_POS 8
`define VBLA_FLOOR_POS 16
`define VBLA_GRAD_POS 24
`define VBLA_LATK_POS 0
`define VBLA_LHOLD_POS 4
`define VBLA_LREL_POS 8
`define VBLA_LSTEP_POS 12
`define VBLA_RSTEP_POS 14
`define VBLA_MAXATT_POS 16
`define VBLA_STH_POS 0
`define VBLA_SATK_POS 8
`define VBLA_SSTEP_POS 12
`define VBLA_SHOLD_POS 16
`define VBLA_FIRST_POS 0
`define VBLA_TXSLOT_POS 8
`define VBLA_LISTEN_POS 16
`define VBLA_CLK_HZ 25000000
`define VBLA_US_PER_MS 1000
`define VBLA_SAG_LAT_US 10
`endif

// ---- tb/vbla_asserts.sv ----
// port-level checks for the vbat limiter
`timescale 1ns/1ps
module vbla_asserts (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // axi4-lite handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // link and state
  input wire serialAudioOutEn,
  input wire shutdownIn,
  input wire powerOff
);
  logic [7:0] enCnt_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // length of the current driven stretch, saturating
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) enCnt_ff <= 8'h00;
    else if (!serialAudioOutEn) enCnt_ff <= 8'h00;
    else if (enCnt_ff != 8'hFF) enCnt_ff <= enCnt_ff + 8'h01;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("no write response");
  a_bresp_holds: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ready_parked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during response");
  a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("response not retired");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed");
  a_off_sticky: assert property ($fell(powerOff) |-> shutdownIn || $past(shutdownIn)
    || $past(shutdownIn, 2)) else $error("power-off left without shutdown");
  a_slot_steady: assert property ($rose(serialAudioOutEn) |-> serialAudioOutEn[*8])
    else $error("slot drive cut short");
  a_slot_length: assert property ($fell(serialAudioOutEn) |-> enCnt_ff >= 8'h3E
    && enCnt_ff <= 8'h42) else $error("slot not eight bit clocks");
endmodule // vbla_asserts

// ---- tb/vbla_limiter_tb.sv ----
// bench for the vbat limiter: registers, sag guard, group alignment
`timescale 1ns/1ps
module vbla_limiter_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [11:0] vbatCode = 12'hC00;
  logic [15:0] peakLevelMv = 16'h0000;
  logic muteIn = 1'b0;
  logic shutdownIn = 1'b0;
  logic run = 1'b0;
  logic [7:0] peerVal = 8'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire tdmBclk, tdmFsync, tdmDin, serialAudioOut, serialAudioOutEn, powerOff;
  wire [7:0] gainReduction, seen;
  logic [31:0] rstVal [5] = '{32'h2, 32'h001E_586E, 32'h0010_5662, 32'h0006_1214, 32'h0};
  logic [7:0] pv [3] = '{8'h14, 8'h14, 8'h00};
  logic [7:0] ge [3] = '{8'h14, 8'h24, 8'h24};
  // limiter knee cases: gradient, vbat code, threshold in mV
  logic [1:0] lg [3] = '{2'h0, 2'h1, 2'h3};
  logic [11:0] lv [3] = '{12'h900, 12'h900, 12'h800};
  logic [15:0] lt [3] = '{16'h2BC0, 16'h283C, 16'h1388};
  logic [31:0] d;
  logic [1:0] r;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  // one tick per microsecond, two per millisecond keep holds short
  vbla_limiter #(.CYC_PER_US(1), .US_PER_MS(2)) dut_u (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vbatCode, .peakLevelMv, .muteIn,
    .shutdownIn, .tdmBclk, .tdmFsync, .tdmDin, .serialAudioOut, .serialAudioOutEn,
    .gainReduction, .powerOff);
  vbla_peer_model peer_u (.run, .peerVal, .peerSlot(3'h3), .capSlot(3'h2),
    .dutOut(serialAudioOut), .dutEn(serialAudioOutEn), .tdmBclk, .tdmFsync,
    .tdmDin, .seen);
  always #20 sys_clk = !sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // write cycle, channels released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      // ready only once the answer waits, so the slave must hold it
      if ((s_axi_bvalid === 1'b1) && (s_axi_bready !== 1'b1)) s_axi_bready <= 1'b1;
    end while ((s_axi_bvalid !== 1'b1) || (s_axi_bready !== 1'b1));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if ((s_axi_rvalid === 1'b1) && (s_axi_rready !== 1'b1)) s_axi_rready <= 1'b1;
    end while ((s_axi_rvalid !== 1'b1) || (s_axi_rready !== 1'b1));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // wait while the reduction still shows a value, bounded
  task automatic wt(input int lim, input logic [7:0] from);
    n = 0;
    while ((gainReduction === from) && (n < lim)) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if ((fails == 0) && (checked > 0)) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4));
      chk(d, rstVal[i]);
    end
    rd(8'h18);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    chk({30'h0, r}, 32'h2);
    // fastest sag attack, short hold, quickest limiter release
    wr(8'h08, 32'h0010_5062);
    wr(8'h0C, 32'h0001_1014);
    wr(8'h00, 32'h0000_0012);
    rd(8'h00);
    chk(d, 32'h2);
    vbatCode <= 12'h4E6;
    wt(14, 8'h00);
    chk(32'(n <= 11), 32'h1);
    chk(32'(gainReduction), 32'h4);
    repeat (3) @(posedge sys_clk);
    chk(32'(gainReduction), 32'h4);
    repeat (5) @(posedge sys_clk);
    chk(32'(gainReduction), 32'h8);
    repeat (60) @(posedge sys_clk);
    chk(32'(gainReduction), 32'h24);
    vbatCode <= 12'hC00;
    wt(200, 8'h24);
    chk(32'(n >= 20), 32'h1);
    chk(32'(gainReduction), 32'h22);
    // endless hold, ended by the strobe, then by mute
    wr(8'h00, 32'h0000_000A);
    for (int k = 0; k < 2; k++) begin
      vbatCode <= 12'h4E6;
      repeat (80) @(posedge sys_clk);
      vbatCode <= 12'hC00;
      repeat (150) @(posedge sys_clk);
      chk(32'(gainReduction), 32'h24);
      if (k == 0) wr(8'h00, 32'h0000_001A);
      else muteIn <= 1'b1;
      wt(100, 8'h24);
      muteIn <= 1'b0;
      chk(32'(gainReduction), 32'h22);
    end
    // power-off survives recovery until a shutdown passes
    wr(8'h00, 32'h0000_0006);
    vbatCode <= 12'h4E6;
    n = 0;
    while ((powerOff !== 1'b1) && (n < 20)) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(powerOff), 32'h1);
    vbatCode <= 12'hC00;
    repeat (50) @(posedge sys_clk);
    chk(32'(powerOff), 32'h1);
    shutdownIn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    shutdownIn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(32'(powerOff), 32'h0);
    // limiter threshold: level just at and just above it, for gradient codes 0, 1 and 3
    wr(8'h00, 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, 32'h001E_586E | (32'(lg[i]) << 24));
      vbatCode <= lv[i];
      for (int k = 0; k < 2; k++) begin
        peakLevelMv <= lt[i] + 16'(k);
        rd(8'h14);
        chk(32'(d[21]), 32'(k));
      end
    end
    peakLevelMv <= 16'h0000;
    // two-member group in slots 2 and 3, each combine mode
    wr(8'h10, 32'h0003_0202);
    wr(8'h00, 32'h0000_0042);
    vbatCode <= 12'h4E6;
    run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      peerVal <= pv[i];
      wr(8'h00, 32'h0000_0062 | (32'(i) << 8));
      repeat (1600) @(posedge sys_clk);
      chk(32'(gainReduction), 32'(ge[i]));
      chk(32'(seen), 32'h24);
    end
    close_out;
  end
endmodule // vbla_limiter_tb
bind vbla_limiter vbla_asserts chk_u (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .serialAudioOutEn, .shutdownIn, .powerOff);

// ---- tb/vbla_peer_model.sv ----
// one peer amplifier and bus master on the shared tdm line
`timescale 1ns/1ps
module vbla_peer_model (
  // control
  input wire run,
  input wire [7:0] peerVal,
  input wire [2:0] peerSlot,
  input wire [2:0] capSlot,
  // device side
  input wire dutOut,
  input wire dutEn,
  output logic tdmBclk,
  output logic tdmFsync,
  output wire tdmDin,
  // byte heard in the capture slot
  output logic [7:0] seen
);
  logic peerOn = 1'b0;
  logic peerBit = 1'b0;
  logic idleBit = 1'b0;
  int b;
  // nobody driving: a toggling level, never the last bit
  assign tdmDin = dutEn ? dutOut : (peerOn ? peerBit : idleBit);
  // eight-slot frames back to back; clock parked low while stopped
  always begin
    if (run !== 1'b1) begin
      tdmBclk = 1'b0;
      tdmFsync = 1'b0;
      seen = 8'h00;
      wait (run === 1'b1);
      // step off the system clock edges so pins never race the sampler
      #10;
    end
    for (b = -1; b < 64; b++) begin
      #160 tdmBclk = 1'b0;
      // sampled late, the driver holds each bit falling to falling
      if ((b > 0) && ((b - 1) / 8 == capSlot)) seen[7 - ((b - 1) & 7)] = tdmDin;
      tdmFsync = (b == -1);
      idleBit = !idleBit;
      peerOn = (b >= 0) && (b / 8 == peerSlot);
      peerBit = peerVal[7 - (b & 7)];
      #160 tdmBclk = 1'b1;
    end
  end
endmodule // vbla_peer_model
